// >>> logic/cmdp_core.sv
// Purpose: Data register, inhibit selects, stack discharge and current
//          generator gating of a 16-bit core memory slave.
// Assumes: Timing phases arrive synchronous to clk_sys_in.
// Notes:   All outputs registered, so they lag their causes by one cycle.
`include "cmdp_defines.svh"
module cmdp_core (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [1:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [15:0] reg_rdata_out,
   input wire logic [1:0] mode_in,
   input wire logic byte_sel_in,
   input wire logic read_only_jumper_in,
   input wire logic power_fail_in,
   input wire cmdp_pkg::cmdp_timing_t timing_in,
   input wire logic [15:0] sense_in,
   input wire logic [15:0] bus_data_in,
   output logic [15:0] bus_data_out,
   output logic bus_data_oe_out,
   output logic [15:0] inhibit_select_out,
   output logic stack_discharge_out,
   output logic current_drive_out,
   output logic generator_supply_out,
   output logic [1:0] transaction_out
);

   cmdp_pkg::cmdp_mode_t dec_mode;
   cmdp_pkg::cmdp_ctl_t dec_ctl;
   cmdp_pkg::cmdp_mode_t mode_reg, mode_next;
   cmdp_pkg::cmdp_ctl_t ctl_reg, ctl_next;
   logic [15:0] memory_data_register_reg, memory_data_register_next;
   logic pause_reg, pause_next;
   logic soft_ro_reg, soft_ro_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [15:0] inh_reg, inh_next;
   logic [15:0] dout_reg, dout_next;
   logic doe_reg, doe_next;
   logic stack_reg, stack_next;
   logic drive_reg, drive_next;
   logic supply_reg, supply_next;
   logic read_only;

   // Merge one byte: clear, then sense preset, bus load wins last
   function automatic logic [7:0] byte_next(input logic [7:0] cur,
         input logic clr, input logic ld, input logic strb,
         input logic [7:0] sense, input logic [7:0] bus);
      logic [7:0] v;
      v = clr ? `CMDP_BYTE_ZERO : cur;
      v = strb ? (v | sense) : v;
      v = ld ? bus : v;
      return v;
   endfunction : byte_next

   assign read_only = read_only_jumper_in | soft_ro_reg;

   cmdp_decode u_decode (
      .mode_in(mode_in),
      .byte_sel_in(byte_sel_in),
      .read_only_in(read_only),
      .pause_in(pause_reg),
      .mode_out(dec_mode),
      .ctl_out(dec_ctl)
   );

   // Transaction and data register
   always_comb begin
      mode_next = mode_reg;
      ctl_next = ctl_reg;
      pause_next = pause_reg;
      memory_data_register_next = memory_data_register_reg;
      if (timing_in.cycle_start) begin
         mode_next = dec_mode;
         ctl_next = dec_ctl;
         pause_next = dec_ctl.set_pause;
         memory_data_register_next[7:0] = byte_next(
            memory_data_register_reg[7:0], dec_ctl.clear_lo,
            dec_ctl.load_lo, 1'b0, `CMDP_BYTE_ZERO, bus_data_in[7:0]);
         memory_data_register_next[15:8] = byte_next(
            memory_data_register_reg[15:8], dec_ctl.clear_hi,
            dec_ctl.load_hi, 1'b0, `CMDP_BYTE_ZERO, bus_data_in[15:8]);
      end else if (timing_in.sense_strobe) begin
         memory_data_register_next[7:0] = byte_next(
            memory_data_register_reg[7:0], 1'b0, 1'b0,
            ctl_reg.strobe_lo, sense_in[7:0], `CMDP_BYTE_ZERO);
         memory_data_register_next[15:8] = byte_next(
            memory_data_register_reg[15:8], 1'b0, 1'b0,
            ctl_reg.strobe_hi, sense_in[15:8], `CMDP_BYTE_ZERO);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         mode_reg <= cmdp_pkg::CMDP_MODE_READ;
         ctl_reg <= '0;
         pause_reg <= 1'b0;
         memory_data_register_reg <= `CMDP_DATA_RESET;
      end else begin
         mode_reg <= mode_next;
         ctl_reg <= ctl_next;
         pause_reg <= pause_next;
         memory_data_register_reg <= memory_data_register_next;
      end
   end

   // Drive-side outputs
   always_comb begin
      // A paused read has no restore, so no inhibit either
      inh_next = (!timing_in.read_phase && timing_in.inhibit_timing_pulse
         && !(pause_reg && mode_reg == cmdp_pkg::CMDP_MODE_READ_PAUSE))
         ? ~memory_data_register_reg : `CMDP_WORD_ZERO;
      stack_next = !timing_in.read_phase
         && timing_in.current_pulse_width;
      // Supply cut is an analogue path too; this covers logic alive
      supply_next = !power_fail_in;
      drive_next = timing_in.current_pulse_width && !power_fail_in;
      doe_next = ctl_reg.data_out && timing_in.data_out_window;
      dout_next = doe_next ? memory_data_register_reg
         : `CMDP_WORD_ZERO;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         inh_reg <= `CMDP_WORD_ZERO;
         stack_reg <= 1'b0;
         supply_reg <= 1'b0;
         drive_reg <= 1'b0;
         doe_reg <= 1'b0;
         dout_reg <= `CMDP_WORD_ZERO;
      end else begin
         inh_reg <= inh_next;
         stack_reg <= stack_next;
         supply_reg <= supply_next;
         drive_reg <= drive_next;
         doe_reg <= doe_next;
         dout_reg <= dout_next;
      end
   end

   // Register port
   always_comb begin
      soft_ro_next = soft_ro_reg;
      rdata_next = `CMDP_WORD_ZERO;
      if (reg_write_in && reg_addr_in == `CMDP_ADDR_CTRL) begin
         soft_ro_next = reg_wdata_in[`CMDP_CTRL_RO_BIT];
      end
      if (reg_read_in) begin
         case (reg_addr_in)
            `CMDP_ADDR_CTRL: begin
               rdata_next[`CMDP_CTRL_RO_BIT] = soft_ro_reg;
            end
            `CMDP_ADDR_STATUS: begin
               rdata_next[1:0] = mode_reg;
               rdata_next[`CMDP_STAT_PAUSE_BIT] = pause_reg;
               rdata_next[`CMDP_STAT_PFAIL_BIT] = power_fail_in;
               rdata_next[`CMDP_STAT_RO_BIT] = read_only;
            end
            `CMDP_ADDR_DATA: begin
               rdata_next = memory_data_register_reg;
            end
            default: begin
               rdata_next = `CMDP_WORD_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         soft_ro_reg <= `CMDP_CTRL_RESET;
         rdata_reg <= `CMDP_WORD_ZERO;
      end else begin
         soft_ro_reg <= soft_ro_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign bus_data_out = dout_reg;
   assign bus_data_oe_out = doe_reg;
   assign inhibit_select_out = inh_reg;
   assign stack_discharge_out = stack_reg;
   assign current_drive_out = drive_reg;
   assign generator_supply_out = supply_reg;
   assign transaction_out = mode_reg;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   sequence s_start_word;
      timing_in.cycle_start && dec_mode == cmdp_pkg::CMDP_MODE_WRITE_WORD;
   endsequence

   chk_word_load: assert property (s_start_word |=>
      memory_data_register_reg == $past(bus_data_in))
      else $error("word write did not load the bus word");
   chk_byte_clear: assert property (timing_in.cycle_start
      && dec_ctl.clear_hi && !dec_ctl.load_hi |=>
      memory_data_register_reg[15:8] == 8'h00)
      else $error("high byte not cleared at cycle start");
   chk_byte_select: assert property (timing_in.cycle_start
      && dec_mode == cmdp_pkg::CMDP_MODE_WRITE_BYTE && byte_sel_in |=>
      memory_data_register_reg[15:8] == $past(bus_data_in[15:8]))
      else $error("byte select loaded wrong byte");
   chk_read_only: assert property (read_only && timing_in.cycle_start
      |=> mode_reg == cmdp_pkg::CMDP_MODE_READ)
      else $error("read-only access not forced to read");
   chk_inhibit_zero: assert property ((inhibit_select_out
      & memory_data_register_reg) == 16'h0000 || $changed(
      memory_data_register_reg))
      else $error("inhibit asserted on a one bit");
   chk_inhibit_read: assert property (timing_in.read_phase ##1
      timing_in.read_phase |-> inhibit_select_out == 16'h0000)
      else $error("inhibit active during read phase");
   chk_stack_read: assert property (timing_in.read_phase |=>
      !stack_discharge_out)
      else $error("stack discharge on during read");
   chk_power_fail: assert property (power_fail_in [*2] |->
      !current_drive_out && !generator_supply_out)
      else $error("current drive kept during power fail");
   chk_bus_release: assert property (bus_data_oe_out |->
      ctl_reg.data_out || $past(ctl_reg.data_out))
      else $error("bus driven outside a read");
   chk_mode_decode: assert property (timing_in.cycle_start && !read_only
      |=> mode_reg == $past(mode_in))
      else $error("transaction decode mismatch");

endmodule : cmdp_core

// >>> logic/cmdp_defines.svh
// Purpose: Register offsets, field positions and reset values for the
//          core memory data path.
// Assumes: Register port carries a 2-bit word index.
// Notes:   Definitions only.
`ifndef CMDP_DEFINES_SVH
`define CMDP_DEFINES_SVH

`define CMDP_ADDR_CTRL 2'h0
`define CMDP_ADDR_STATUS 2'h1
`define CMDP_ADDR_DATA 2'h2

`define CMDP_CTRL_RO_BIT 0
`define CMDP_STAT_PAUSE_BIT 2
`define CMDP_STAT_PFAIL_BIT 3
`define CMDP_STAT_RO_BIT 4

`define CMDP_CTRL_RESET 1'h0
`define CMDP_DATA_RESET 16'h0000
`define CMDP_WORD_ZERO 16'h0000
`define CMDP_BYTE_ZERO 8'h00

`endif

// >>> logic/cmdp_pkg.sv
// Purpose: Types shared by the core memory data path modules.
// Assumes: Nothing beyond one system clock.
// Notes:   Mode codes follow the bus mode-control encoding.
package cmdp_pkg;

   typedef enum logic [1:0] {
      CMDP_MODE_READ = 2'b00,
      CMDP_MODE_READ_PAUSE = 2'b01,
      CMDP_MODE_WRITE_WORD = 2'b10,
      CMDP_MODE_WRITE_BYTE = 2'b11
   } cmdp_mode_t;

   // Phase signals from the external timing generator
   typedef struct packed {
      logic cycle_start;
      logic read_phase;
      logic current_pulse_width;
      logic inhibit_timing_pulse;
      logic sense_strobe;
      logic data_out_window;
   } cmdp_timing_t;

   // Per-transaction enables for the data register
   typedef struct packed {
      logic clear_lo;
      logic clear_hi;
      logic strobe_lo;
      logic strobe_hi;
      logic load_lo;
      logic load_hi;
      logic data_out;
      logic set_pause;
   } cmdp_ctl_t;

endpackage : cmdp_pkg

// >>> logic/cmdp_decode.sv
// Purpose: Decode mode-control bits, byte select and pause state into
//          data register enables.
// Assumes: Inputs stable while the transaction is being started.
// Notes:   Purely combinational.
module cmdp_decode (
   input wire logic [1:0] mode_in,
   input wire logic byte_sel_in,
   input wire logic read_only_in,
   input wire logic pause_in,
   output cmdp_pkg::cmdp_mode_t mode_out,
   output cmdp_pkg::cmdp_ctl_t ctl_out
);

   logic [1:0] gated_mode;

   always_comb begin
      // Protect gate: forced high turns every access into a read
      gated_mode = read_only_in ? 2'h0 : mode_in;
      mode_out = cmdp_pkg::cmdp_mode_t'(gated_mode);
      ctl_out = '0;
      case (mode_out)
         cmdp_pkg::CMDP_MODE_READ: begin
            ctl_out = 8'hF2;
         end
         cmdp_pkg::CMDP_MODE_READ_PAUSE: begin
            ctl_out = 8'hF3;
         end
         cmdp_pkg::CMDP_MODE_WRITE_WORD: begin
            // After a paused read the clear step is skipped as well
            ctl_out.clear_lo = !pause_in;
            ctl_out.clear_hi = !pause_in;
            ctl_out.load_lo = 1'b1;
            ctl_out.load_hi = 1'b1;
         end
         cmdp_pkg::CMDP_MODE_WRITE_BYTE: begin
            // Non-selected byte is cleared and re-sensed for restore,
            // unless a paused read already holds it: its cores are empty
            ctl_out.load_hi = byte_sel_in;
            ctl_out.load_lo = !byte_sel_in;
            ctl_out.clear_lo = byte_sel_in && !pause_in;
            ctl_out.strobe_lo = byte_sel_in && !pause_in;
            ctl_out.clear_hi = !byte_sel_in && !pause_in;
            ctl_out.strobe_hi = !byte_sel_in && !pause_in;
         end
         default: begin
            ctl_out = '0;
         end
      endcase
   end

endmodule : cmdp_decode

// >>> sim/cmdp_bus_master.sv
// Purpose: Far side of the data path: bus master plus phase generator.
// Assumes: One transaction at a time, phases issued by the bench.
// Notes:   Released bus and sense lines show the inverse of the last value; timing drops to zero.
module cmdp_bus_master (
   input wire logic clk_sys_in,
   output logic [1:0] mode_out,
   output logic byte_sel_out,
   output logic [15:0] bus_data_out,
   output logic [15:0] sense_out,
   output cmdp_pkg::cmdp_timing_t timing_out
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      mode_out = 2'b00;
      byte_sel_out = 1'b0;
      bus_data_out = 16'h0000;
      sense_out = 16'h0000;
      timing_out = '0;
   end

   // Mode, byte select and word stay put through the start cycle
   task automatic start(input logic [1:0] mode, input logic sel,
                        input logic [15:0] data);
      @(posedge clk_sys_in);
      mode_out <= mode;
      byte_sel_out <= sel;
      bus_data_out <= data;
      timing_out <= 6'h20;
      @(posedge clk_sys_in);
      timing_out <= '0;
      bus_data_out <= ~data;
   endtask : start

   task automatic phase(input logic [5:0] t, input logic [15:0] s);
      @(posedge clk_sys_in);
      timing_out <= t;
      sense_out <= s;
      @(posedge clk_sys_in);
      timing_out <= '0;
      sense_out <= ~s;
   endtask : phase
endmodule : cmdp_bus_master

// >>> sim/tb_core_memory_data_path.sv
// Purpose: Self-checking bench for the core memory data path.
// Assumes: Register reads answer in the cycle after the strobe.
// Notes:   Checks land on the falling edge, clear of the launch edge.
module tb_core_memory_data_path;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic [1:0] reg_addr_in = 2'h0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic reg_write_in = 1'b0;
   logic reg_read_in = 1'b0;
   logic read_only_jumper_in = 1'b0;
   logic power_fail_in = 1'b0;
   logic [1:0] mode, trans;
   logic byte_sel, oe, stack, drive, supply;
   logic [15:0] rdata, bus_in, bus_out, sense, inhibit;
   cmdp_pkg::cmdp_timing_t timing;
   int n_errors = 0;
   int tests_run = 0;

   always #50 clk_sys_in = ~clk_sys_in;

   cmdp_bus_master master (
      .clk_sys_in(clk_sys_in),
      .mode_out(mode),
      .byte_sel_out(byte_sel),
      .bus_data_out(bus_in),
      .sense_out(sense),
      .timing_out(timing)
   );

   cmdp_core dut (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_write_in(reg_write_in),
      .reg_read_in(reg_read_in),
      .reg_rdata_out(rdata),
      .mode_in(mode),
      .byte_sel_in(byte_sel),
      .read_only_jumper_in(read_only_jumper_in),
      .power_fail_in(power_fail_in),
      .timing_in(timing),
      .sense_in(sense),
      .bus_data_in(bus_in),
      .bus_data_out(bus_out),
      .bus_data_oe_out(oe),
      .inhibit_select_out(inhibit),
      .stack_discharge_out(stack),
      .current_drive_out(drive),
      .generator_supply_out(supply),
      .transaction_out(trans)
   );

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_write_in <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [1:0] a, input logic [15:0] exp);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_read_in <= 1'b0;
      @(negedge clk_sys_in);
      chk(rdata, exp);
   endtask : reg_rd

   // Phase codes: start, read, width, inhibit, strobe, data window
   task automatic ph(input logic [5:0] t, input logic [15:0] s);
      master.phase(t, s);
      @(negedge clk_sys_in);
   endtask : ph

   initial begin
      repeat (5000) @(posedge clk_sys_in);
      n_errors++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      @(negedge clk_sys_in);
      chk({15'h0000, supply}, 16'h0000);
      @(negedge clk_sys_in);
      chk({15'h0000, supply}, 16'h0001);
      reg_rd(2'h2, 16'h0000);
      reg_wr(2'h1, 16'hFFFF);
      reg_rd(2'h3, 16'h0000);
      reg_rd(2'h1, 16'h0000);
      master.start(2'b10, 1'b0, 16'hA5C3);
      @(negedge clk_sys_in);
      chk({14'h0000, trans}, 16'h0002);
      reg_rd(2'h2, 16'hA5C3);
      ph(6'h0C, 16'hFFFF);
      chk(inhibit, 16'h5A3C);
      chk({15'h0000, stack}, 16'h0001);
      chk({15'h0000, drive}, 16'h0001);
      @(negedge clk_sys_in);
      chk(inhibit, 16'h0000);
      ph(6'h01, 16'h0000);
      chk({oe, bus_out[14:0]}, 16'h0000);
      master.start(2'b00, 1'b0, 16'hFFFF);
      ph(6'h12, 16'h1234);
      ph(6'h18, 16'h0000);
      chk({15'h0000, stack}, 16'h0000);
      ph(6'h11, 16'h0000);
      chk({15'h0000, oe}, 16'h0001);
      chk(bus_out, 16'h1234);
      ph(6'h0C, 16'h0000);
      chk(inhibit, 16'hEDCB);
      // Sense may only reach the byte that is not being written
      master.start(2'b11, 1'b1, 16'hBEEF);
      ph(6'h12, 16'h0F0F);
      reg_rd(2'h2, 16'hBE0F);
      master.start(2'b11, 1'b0, 16'h77AB);
      ph(6'h12, 16'h0F0F);
      reg_rd(2'h2, 16'h0FAB);
      reg_rd(2'h1, 16'h0003);
      master.start(2'b01, 1'b0, 16'h0000);
      ph(6'h12, 16'h0F0F);
      reg_rd(2'h1, 16'h0005);
      ph(6'h0C, 16'h0000);
      chk(inhibit, 16'h0000);
      master.start(2'b10, 1'b0, 16'h1111);
      reg_rd(2'h2, 16'h1111);
      reg_rd(2'h1, 16'h0002);
      // A byte write after a paused read keeps the other byte as read
      master.start(2'b01, 1'b0, 16'h0000);
      ph(6'h12, 16'h3C3C);
      master.start(2'b11, 1'b1, 16'hC300);
      ph(6'h12, 16'h00F0);
      reg_rd(2'h2, 16'hC33C);
      @(posedge clk_sys_in);
      read_only_jumper_in <= 1'b1;
      master.start(2'b10, 1'b0, 16'h5555);
      ph(6'h12, 16'h00AA);
      reg_rd(2'h2, 16'h00AA);
      reg_rd(2'h1, 16'h0010);
      @(posedge clk_sys_in);
      read_only_jumper_in <= 1'b0;
      reg_wr(2'h0, 16'h0001);
      master.start(2'b11, 1'b1, 16'h5555);
      reg_rd(2'h1, 16'h0010);
      reg_wr(2'h0, 16'h0000);
      reg_rd(2'h0, 16'h0000);
      @(posedge clk_sys_in);
      power_fail_in <= 1'b1;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({15'h0000, supply}, 16'h0000);
      reg_rd(2'h1, 16'h0008);
      ph(6'h08, 16'h0000);
      chk({15'h0000, drive}, 16'h0000);
      chk({15'h0000, stack}, 16'h0001);
      @(posedge clk_sys_in);
      power_fail_in <= 1'b0;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({15'h0000, supply}, 16'h0001);
      conclude();
   end
endmodule : tb_core_memory_data_path
